// file: fq_regs.svh
// Register offsets, flash command values and pin timing for the flash query host
`ifndef FQ_REGS_SVH
`define FQ_REGS_SVH

`define FQ_OFF_CMD      8'h00
`define FQ_OFF_ADDR     8'h04
`define FQ_OFF_WDATA    8'h08
`define FQ_OFF_RDATA    8'h0c
`define FQ_OFF_STATUS   8'h10

`define FQ_ST_BUSY      0
`define FQ_ST_MODE_LO   1
`define FQ_ST_MODE_HI   2
`define FQ_ST_TOUT      3

`define FQ_QUERY_CMD    8'h98
`define FQ_QUERY_ADDR   22'h000055
`define FQ_IDENT_CMD    8'h90
`define FQ_RESET_CMD    8'hf0
`define FQ_TOUT_BIT     5

`define FQ_CLK_MHZ      10
`define FQ_T_AS_NS      50
`define FQ_T_WP_NS      100
`define FQ_T_DH_NS      50
`define FQ_T_RD_NS      100

`define FQ_RESP_OKAY    2'b00
`define FQ_RESP_SLVERR  2'b10

`endif

// file: fq_pkg.sv
// Types shared by the flash query host
package fq_pkg;

  typedef enum logic [2:0] {
    FQ_IDLE    = 3'b000,
    FQ_W_ADDR  = 3'b001,
    FQ_W_PULSE = 3'b010,
    FQ_W_HOLD  = 3'b011,
    FQ_R_ACC   = 3'b100,
    FQ_R_END   = 3'b101
  } fq_state_type;

  typedef enum logic [1:0] {
    FQ_MODE_ARRAY = 2'b00,
    FQ_MODE_IDENT = 2'b01,
    FQ_MODE_QUERY = 2'b10
  } fq_mode_type;

  typedef enum logic [2:0] {
    FQ_OP_NONE  = 3'b000,
    FQ_OP_WRITE = 3'b001,
    FQ_OP_READ  = 3'b010,
    FQ_OP_QUERY = 3'b011,
    FQ_OP_RESET = 3'b100,
    FQ_OP_POLL  = 3'b101
  } fq_op_type;

endpackage

// file: fq_phase_timer.sv
// Down counter that times one phase of a flash bus cycle
`timescale 1ns/1ps
module fq_phase_timer #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  output logic              o_done
);
  logic [W-1:0] cnt_r;
  logic         run_r;

  assign o_done = run_r && (cnt_r == '0);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (i_load) begin
      // Count N means the phase lasts N cycles after the load
      cnt_r <= i_count - W'(1);
      run_r <= 1'b1;
    end else if (o_done) begin
      run_r <= 1'b0;
    end else if (run_r) begin
      cnt_r <= cnt_r - W'(1);
    end
  end
endmodule

// file: fq_host.sv
// Flash query host: AXI4-Lite register slave driving a byte-wide flash bus
`timescale 1ns/1ps
`include "fq_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module fq_host #(
  parameter int AW = 22
) (
  input  wire logic          I_CLK_SYS,
  input  wire logic          I_RST_N,
  input  wire logic [7:0]    I_AXI_AWADDR,
  input  wire logic          I_AXI_AWVALID,
  output logic               O_AXI_AWREADY,
  input  wire logic [31:0]   I_AXI_WDATA,
  input  wire logic [3:0]    I_AXI_WSTRB,
  input  wire logic          I_AXI_WVALID,
  output logic               O_AXI_WREADY,
  output logic [1:0]         O_AXI_BRESP,
  output logic               O_AXI_BVALID,
  input  wire logic          I_AXI_BREADY,
  input  wire logic [7:0]    I_AXI_ARADDR,
  input  wire logic          I_AXI_ARVALID,
  output logic               O_AXI_ARREADY,
  output logic [31:0]        O_AXI_RDATA,
  output logic [1:0]         O_AXI_RRESP,
  output logic               O_AXI_RVALID,
  input  wire logic          I_AXI_RREADY,
  output logic [AW-1:0]      O_FL_ADDR,
  output logic [7:0]         O_FL_DQ_O,
  output logic               O_FL_DQ_OE,
  input  wire logic [7:0]    I_FL_DQ_I,
  output logic               O_FL_CE_N,
  output logic               O_FL_OE_N,
  output logic               O_FL_WE_N
);
  localparam int T_AS_CYC = ((`FQ_T_AS_NS * `FQ_CLK_MHZ + 999) / 1000) < 1 ? 1 :
                            ((`FQ_T_AS_NS * `FQ_CLK_MHZ + 999) / 1000);
  localparam int T_WP_CYC = ((`FQ_T_WP_NS * `FQ_CLK_MHZ + 999) / 1000) < 1 ? 1 :
                            ((`FQ_T_WP_NS * `FQ_CLK_MHZ + 999) / 1000);
  localparam int T_DH_CYC = ((`FQ_T_DH_NS * `FQ_CLK_MHZ + 999) / 1000) < 1 ? 1 :
                            ((`FQ_T_DH_NS * `FQ_CLK_MHZ + 999) / 1000);
  localparam int T_RD_CYC = ((`FQ_T_RD_NS * `FQ_CLK_MHZ + 999) / 1000) < 1 ? 1 :
                            ((`FQ_T_RD_NS * `FQ_CLK_MHZ + 999) / 1000);

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [7:0]            awaddr_r;
  logic [31:0]           wdata_bus_r;
  logic [3:0]            wstrb_r;
  logic                  aw_held_r;
  logic                  w_held_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;
  logic                  rvalid_r;
  logic [31:0]           rdata_bus_r;
  logic [1:0]            rresp_r;
  logic [AW-1:0]         addr_r;
  logic [7:0]            wdata_r;
  logic [7:0]            rdata_r;
  fq_pkg::fq_op_type     op_r;
  fq_pkg::fq_state_type  state_r;
  fq_pkg::fq_state_type  state_nxt;
  fq_pkg::fq_mode_type   mode_r;
  fq_pkg::fq_mode_type   mode_nxt;
  fq_pkg::fq_mode_type   ret_r;
  logic                  tout_r;
  logic                  tout_nxt;

  wire aw_hs    = I_AXI_AWVALID && O_AXI_AWREADY;
  wire w_hs     = I_AXI_WVALID && O_AXI_WREADY;
  wire ar_hs    = I_AXI_ARVALID && O_AXI_ARREADY;
  wire wr_do    = aw_held_r && w_held_r && !bvalid_r;
  wire busy     = (state_r != fq_pkg::FQ_IDLE);
  wire hit_cmd  = (awaddr_r == `FQ_OFF_CMD);
  wire hit_addr = (awaddr_r == `FQ_OFF_ADDR);
  wire hit_wdat = (awaddr_r == `FQ_OFF_WDATA);
  wire wr_ok    = hit_cmd || hit_addr || hit_wdat;
  wire [2:0] cmd_op = wdata_bus_r[2:0];
  wire cmd_known = (cmd_op >= 3'h1) && (cmd_op <= 3'h5);
  // Orders that arrive while a bus cycle runs are dropped; software polls busy first
  wire go = wr_do && hit_cmd && wstrb_r[0] && !busy && cmd_known;

  wire [31:0] status_word = {28'h0000000, tout_r, mode_r, busy};
  wire [7:0]  ar_a        = I_AXI_ARADDR;
  wire        rd_ok       = (ar_a == `FQ_OFF_CMD) || (ar_a == `FQ_OFF_ADDR) || (ar_a == `FQ_OFF_WDATA) ||
                            (ar_a == `FQ_OFF_RDATA) || (ar_a == `FQ_OFF_STATUS);
  wire [31:0] rd_mux =
    (ar_a == `FQ_OFF_CMD)    ? {29'h00000000, op_r} :
    (ar_a == `FQ_OFF_ADDR)   ? {{(32-AW){1'b0}}, addr_r} :
    (ar_a == `FQ_OFF_WDATA)  ? {24'h000000, wdata_r} :
    (ar_a == `FQ_OFF_RDATA)  ? {24'h000000, rdata_r} :
    (ar_a == `FQ_OFF_STATUS) ? status_word : 32'h00000000;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  wire [31:0] addr_merged  = merge({{(32-AW){1'b0}}, addr_r}, wdata_bus_r, wstrb_r);
  wire [31:0] wdata_merged = merge({24'h000000, wdata_r}, wdata_bus_r, wstrb_r);

  assign O_AXI_AWREADY = !aw_held_r && !bvalid_r;
  assign O_AXI_WREADY  = !w_held_r && !bvalid_r;
  assign O_AXI_BVALID  = bvalid_r;
  assign O_AXI_BRESP   = bresp_r;
  assign O_AXI_ARREADY = !rvalid_r;
  assign O_AXI_RVALID  = rvalid_r;
  assign O_AXI_RDATA   = rdata_bus_r;
  assign O_AXI_RRESP   = rresp_r;

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      aw_held_r   <= 1'b0;
      w_held_r    <= 1'b0;
      awaddr_r    <= 8'h00;
      wdata_bus_r <= 32'h00000000;
      wstrb_r     <= 4'h0;
      bvalid_r    <= 1'b0;
      bresp_r     <= `FQ_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= I_AXI_AWADDR;
      end
      if (w_hs) begin
        w_held_r    <= 1'b1;
        wdata_bus_r <= I_AXI_WDATA;
        wstrb_r     <= I_AXI_WSTRB;
      end
      if (wr_do) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? `FQ_RESP_OKAY : `FQ_RESP_SLVERR;
      end else if (bvalid_r && I_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      rvalid_r    <= 1'b0;
      rdata_bus_r <= 32'h00000000;
      rresp_r     <= `FQ_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_r    <= 1'b1;
      rdata_bus_r <= rd_mux;
      rresp_r     <= rd_ok ? `FQ_RESP_OKAY : `FQ_RESP_SLVERR;
    end else if (rvalid_r && I_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // Address and data stay writable while busy; the cycle uses its own latched copies
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      addr_r  <= '0;
      wdata_r <= 8'h00;
      op_r    <= fq_pkg::FQ_OP_NONE;
    end else begin
      if (wr_do && hit_addr) begin
        addr_r <= addr_merged[AW-1:0];
      end
      if (wr_do && hit_wdat) begin
        wdata_r <= wdata_merged[7:0];
      end
      if (go) begin
        op_r <= fq_pkg::fq_op_type'(cmd_op);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flash bus cycle sequencer
  logic          t_done;
  logic [7:0]    t_count;
  logic [AW-1:0] cyc_addr_r;
  logic [7:0]    cyc_data_r;

  wire is_read_op = (fq_pkg::fq_op_type'(cmd_op) == fq_pkg::FQ_OP_READ) ||
                    (fq_pkg::fq_op_type'(cmd_op) == fq_pkg::FQ_OP_POLL);
  wire [AW-1:0] go_addr = (fq_pkg::fq_op_type'(cmd_op) == fq_pkg::FQ_OP_QUERY) ?
                          AW'(`FQ_QUERY_ADDR) : addr_r;
  wire [7:0] go_data = (fq_pkg::fq_op_type'(cmd_op) == fq_pkg::FQ_OP_QUERY) ? `FQ_QUERY_CMD :
                       (fq_pkg::fq_op_type'(cmd_op) == fq_pkg::FQ_OP_RESET) ? `FQ_RESET_CMD : wdata_r;
  wire wr_end = (state_r == fq_pkg::FQ_W_HOLD) && t_done;
  wire rd_smp = (state_r == fq_pkg::FQ_R_ACC) && t_done;
  wire t_load = go || (t_done && (state_r != fq_pkg::FQ_W_HOLD) && (state_r != fq_pkg::FQ_R_END));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fq_pkg::FQ_IDLE:    if (go) state_nxt = is_read_op ? fq_pkg::FQ_R_ACC : fq_pkg::FQ_W_ADDR;
      fq_pkg::FQ_W_ADDR:  if (t_done) state_nxt = fq_pkg::FQ_W_PULSE;
      fq_pkg::FQ_W_PULSE: if (t_done) state_nxt = fq_pkg::FQ_W_HOLD;
      fq_pkg::FQ_W_HOLD:  if (t_done) state_nxt = fq_pkg::FQ_IDLE;
      fq_pkg::FQ_R_ACC:   if (t_done) state_nxt = fq_pkg::FQ_R_END;
      fq_pkg::FQ_R_END:   if (t_done) state_nxt = fq_pkg::FQ_IDLE;
      default:            state_nxt = fq_pkg::FQ_IDLE;
    endcase
  end

  assign t_count = (state_nxt == fq_pkg::FQ_W_ADDR)  ? 8'(T_AS_CYC) :
                   (state_nxt == fq_pkg::FQ_W_PULSE) ? 8'(T_WP_CYC) :
                   (state_nxt == fq_pkg::FQ_R_ACC)   ? 8'(T_RD_CYC) : 8'(T_DH_CYC);

  fq_phase_timer #(.W(8)) u_timer (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .i_load  (t_load),
    .i_count (t_count),
    .o_done  (t_done)
  );

  // Chip select opens the write with the write strobe high, so the strobe falls last and rises first
  wire ce_nxt = (state_nxt != fq_pkg::FQ_IDLE);
  wire we_nxt = (state_nxt == fq_pkg::FQ_W_PULSE);
  wire oe_nxt = (state_nxt == fq_pkg::FQ_R_ACC);
  wire dq_nxt = (state_nxt == fq_pkg::FQ_W_ADDR) || we_nxt || (state_nxt == fq_pkg::FQ_W_HOLD);

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      state_r    <= fq_pkg::FQ_IDLE;
      cyc_addr_r <= '0;
      cyc_data_r <= 8'h00;
      O_FL_CE_N  <= 1'b1;
      O_FL_WE_N  <= 1'b1;
      O_FL_OE_N  <= 1'b1;
      O_FL_DQ_OE <= 1'b0;
      rdata_r    <= 8'h00;
    end else begin
      state_r    <= state_nxt;
      O_FL_CE_N  <= !ce_nxt;
      O_FL_WE_N  <= !we_nxt;
      O_FL_OE_N  <= !oe_nxt;
      O_FL_DQ_OE <= dq_nxt;
      if (go) begin
        cyc_addr_r <= go_addr;
        cyc_data_r <= go_data;
      end
      if (rd_smp) begin
        rdata_r <= I_FL_DQ_I;
      end
    end
  end

  assign O_FL_ADDR = cyc_addr_r;
  assign O_FL_DQ_O = cyc_data_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Mirror of the device's read mode
  wire tout_set = rd_smp && (op_r == fq_pkg::FQ_OP_POLL) && I_FL_DQ_I[`FQ_TOUT_BIT];
  wire tout_clr = wr_end && (op_r == fq_pkg::FQ_OP_RESET);
  assign tout_nxt = tout_set || (tout_r && !tout_clr);

  always_comb begin
    mode_nxt = mode_r;
    if (wr_end) begin
      case (op_r)
        fq_pkg::FQ_OP_QUERY: mode_nxt = fq_pkg::FQ_MODE_QUERY;
        fq_pkg::FQ_OP_RESET: mode_nxt = (mode_r == fq_pkg::FQ_MODE_QUERY) ? ret_r :
                                        fq_pkg::FQ_MODE_ARRAY;
        fq_pkg::FQ_OP_WRITE: begin
          if (cyc_data_r == `FQ_IDENT_CMD) begin
            mode_nxt = fq_pkg::FQ_MODE_IDENT;
          end else if (mode_r != fq_pkg::FQ_MODE_ARRAY) begin
            mode_nxt = fq_pkg::FQ_MODE_ARRAY;
          end
        end
        default: mode_nxt = mode_r;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      mode_r <= fq_pkg::FQ_MODE_ARRAY;
      ret_r  <= fq_pkg::FQ_MODE_ARRAY;
      tout_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      tout_r <= tout_nxt;
      if (wr_end && (op_r == fq_pkg::FQ_OP_QUERY) && (mode_r != fq_pkg::FQ_MODE_QUERY)) begin
        ret_r <= mode_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_query_entry_pins: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (!O_FL_WE_N && op_r == fq_pkg::FQ_OP_QUERY) |-> (O_FL_DQ_O == 8'h98 && O_FL_ADDR == AW'(22'h000055)))
    else $error("query entry not 98h at 55h");
  a_query_mode_set: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (wr_end && op_r == fq_pkg::FQ_OP_QUERY) |=> (mode_r == fq_pkg::FQ_MODE_QUERY))
    else $error("query mode not entered");
  a_reset_to_array: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (wr_end && op_r == fq_pkg::FQ_OP_RESET && mode_r == fq_pkg::FQ_MODE_QUERY &&
     ret_r == fq_pkg::FQ_MODE_ARRAY) |=> (mode_r == fq_pkg::FQ_MODE_ARRAY))
    else $error("reset did not return to array");
  a_reset_to_ident: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (wr_end && op_r == fq_pkg::FQ_OP_RESET && mode_r == fq_pkg::FQ_MODE_QUERY &&
     ret_r == fq_pkg::FQ_MODE_IDENT) |=> (mode_r == fq_pkg::FQ_MODE_IDENT))
    else $error("reset did not return to identifier mode");
  a_addr_at_we_fall: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    $fell(O_FL_WE_N) |-> ($past(O_FL_CE_N) == 1'b0 && $stable(O_FL_ADDR) && O_FL_DQ_OE))
    else $error("write strobe fell before chip select");
  a_data_at_we_rise: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    $rose(O_FL_WE_N) |-> (!O_FL_CE_N && O_FL_DQ_OE && $stable(O_FL_DQ_O)) ##1 (O_FL_DQ_OE || O_FL_CE_N))
    else $error("chip select rose before write strobe");
  a_tout_cleared: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (wr_end && op_r == fq_pkg::FQ_OP_RESET) |=> !tout_r)
    else $error("timeout flag kept after reset command");
  a_no_contention: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !O_FL_OE_N |-> (!O_FL_DQ_OE && O_FL_WE_N))
    else $error("host drives data while flash outputs");
  a_write_length: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    $fell(O_FL_WE_N) |-> !O_FL_WE_N [*1] ##1 O_FL_WE_N)
    else $error("write pulse length wrong");

  c_query_entry: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    wr_end && op_r == fq_pkg::FQ_OP_QUERY);
  c_reset_ident: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    wr_end && op_r == fq_pkg::FQ_OP_RESET && mode_r == fq_pkg::FQ_MODE_QUERY && ret_r == fq_pkg::FQ_MODE_IDENT);
  c_tout_seen: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) tout_set);
  c_read_done: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) rd_smp);
endmodule

// file: fq_flash_model.sv
// Behavioural byte-wide flash device answering query, identifier and reset commands
`timescale 1ns/1ps
module fq_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h3c  // Arbitrary identifier value
) (
  input  wire logic [21:0] i_addr,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_timeout_status_bit,
  output logic      [7:0]  o_dq,
  output logic      [1:0]  o_mode,
  output logic      [21:0] o_last_addr,
  output logic      [7:0]  o_last_data
);
  // Query bytes for offsets 10h to 4Ch
  localparam logic [7:0] QTAB [0:60] = '{
    8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h27, 8'h36, 8'h00, 8'h00, 8'h04,
    8'h00, 8'h0a, 8'h00, 8'h05, 8'h00, 8'h04, 8'h00, 8'h16,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h3f, 8'h00, 8'h00,
    8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h50, 8'h52, 8'h49, 8'h31, 8'h30, 8'h01, 8'h02, 8'h01,
    8'h04, 8'h04, 8'h20, 8'h00, 8'h00
  };
  logic [1:0] mode_r = 2'd0;
  logic [1:0] prev_r = 2'd0;
  logic [7:0] rd_val;
  logic [7:0] last_q = 8'h00;
  wire        wr_n   = i_ce_n | i_we_n;
  wire        drv    = !i_ce_n && !i_oe_n;

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge wr_n) begin
    o_last_addr = i_addr;
  end

  always @(posedge wr_n) begin
    if (i_oe_n === 1'b1) begin
      o_last_data = i_dq;
      if (i_dq == 8'h98 && o_last_addr == 22'h000055 && mode_r != 2'd2) begin
        prev_r = mode_r;
        mode_r = 2'd2;
      end else if (i_dq == 8'hf0) begin
        mode_r = (mode_r == 2'd2) ? prev_r : 2'd0;
      end else if (i_dq == 8'h90) begin
        // Identifier entry is cut to its last cycle; unlock cycles are not modelled
        mode_r = 2'd1;
      end else begin
        mode_r = 2'd0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (mode_r)
      2'd1: rd_val = ID_CODE;
      2'd2: rd_val = (i_addr[7:0] >= 8'h10 && i_addr[7:0] <= 8'h4c) ? QTAB[i_addr[7:0] - 8'h10] : 8'h00;
      default: rd_val = (i_addr[7:0] ^ 8'ha5) | {2'b00, i_timeout_status_bit, 5'b00000};
    endcase
  end

  // A released bus shows the inverse of the last byte, so a late sample never passes
  always @* begin
    if (drv) last_q = rd_val;
  end
  assign o_dq   = drv ? rd_val : ~last_q;
  assign o_mode = mode_r;
endmodule

// file: test_fq_host.sv
// Self-checking bench for the flash query host driving the flash device model
`timescale 1ns/1ps
`include "fq_regs.svh"
`define FQ_CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module test_fq_host;
  localparam logic [7:0] ID_CODE = 8'h3c;  // Arbitrary identifier value
  localparam logic [7:0] QEXP [0:60] = '{
    8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h27, 8'h36, 8'h00, 8'h00, 8'h04,
    8'h00, 8'h0a, 8'h00, 8'h05, 8'h00, 8'h04, 8'h00, 8'h16, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h3f, 8'h00, 8'h00,
    8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h50, 8'h52, 8'h49, 8'h31, 8'h30, 8'h01, 8'h02, 8'h01, 8'h04, 8'h04, 8'h20, 8'h00, 8'h00};
  logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        dq_oe, ce_n, oe_n, we_n, timeout_status_bit;
  logic [1:0]  bresp, rresp, mdl_mode;
  logic [3:0]  wstrb;
  logic [7:0]  awaddr, araddr, dq_o, mdl_dq, dq_bus, last_data;
  logic [21:0] fl_addr, last_addr;
  logic [31:0] wdata, rdata, d;
  int          check_count, n_fail;

  assign dq_bus = dq_oe ? dq_o : mdl_dq;

  fq_host DUT (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
    .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid),
    .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
    .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready), .O_AXI_RDATA(rdata),
    .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready), .O_FL_ADDR(fl_addr),
    .O_FL_DQ_O(dq_o), .O_FL_DQ_OE(dq_oe), .I_FL_DQ_I(dq_bus), .O_FL_CE_N(ce_n), .O_FL_OE_N(oe_n),
    .O_FL_WE_N(we_n));

  fq_flash_model #(.ID_CODE(ID_CODE)) flash_mdl (.i_addr(fl_addr), .i_dq(dq_bus), .i_ce_n(ce_n),
    .i_oe_n(oe_n), .i_we_n(we_n), .i_timeout_status_bit(timeout_status_bit), .o_dq(mdl_dq),
    .o_mode(mdl_mode), .o_last_addr(last_addr), .o_last_data(last_data));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic timed_out;
    n_fail++;
    $display("mismatch at %0t: wait ran out", $time);
    give_verdict();
  endtask

  // Ready and response are read before this edge's updates land
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (int n = 0; n <= 40; n++) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
      if (n == 40) timed_out();
    end
    `FQ_CHK(bresp, er)
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    for (int n = 0; n <= 40; n++) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
      if (n == 40) timed_out();
    end
    v = rdata;
    `FQ_CHK(rresp, er)
  endtask

  task automatic fl_op(input fq_pkg::fq_op_type op, input logic [21:0] a, input logic [7:0] v);
    logic [31:0] s;
    axi_wr(`FQ_OFF_ADDR, {10'h000, a}, `FQ_RESP_OKAY);
    axi_wr(`FQ_OFF_WDATA, {24'h000000, v}, `FQ_RESP_OKAY);
    axi_wr(`FQ_OFF_CMD, {29'h00000000, op}, `FQ_RESP_OKAY);
    for (int n = 0; n <= 50; n++) begin
      axi_rd(`FQ_OFF_STATUS, s, `FQ_RESP_OKAY);
      if (s[`FQ_ST_BUSY] === 1'b0) break;
      if (n == 50) timed_out();
    end
  endtask

  task automatic frd(input logic [21:0] a, input logic [7:0] e);
    logic [31:0] r;
    fl_op(fq_pkg::FQ_OP_READ, a, 8'h00);
    axi_rd(`FQ_OFF_RDATA, r, `FQ_RESP_OKAY);
    `FQ_CHK(r[7:0], e)
  endtask

  task automatic st_chk(input logic [1:0] m, input logic t);
    logic [31:0] r;
    axi_rd(`FQ_OFF_STATUS, r, `FQ_RESP_OKAY);
    `FQ_CHK(r[3:1], {t, m})
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    check_count = 0;
    n_fail = 0;
    {rst_n, awvalid, wvalid, arvalid, timeout_status_bit} = 5'b00000;
    {bready, rready, wstrb} = 6'h3f;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    st_chk(2'd0, 1'b0);
    frd(22'h000033, 8'h33 ^ 8'ha5);
    axi_rd(8'h14, d, `FQ_RESP_SLVERR);
    `FQ_CHK(d, 32'h00000000)
    axi_wr(`FQ_OFF_RDATA, 32'h0000005a, `FQ_RESP_SLVERR);
    fl_op(fq_pkg::FQ_OP_QUERY, 22'h000000, 8'h00);
    st_chk(2'd2, 1'b0);
    `FQ_CHK(mdl_mode, 2'd2)
    for (int i = 0; i < 16; i++) begin
      frd(i[21:0], 8'h00);
    end
    for (int i = 16; i < 8'h30; i++) begin
      frd(i[21:0], QEXP[i - 16]);
    end
    for (int i = 8'h30; i <= 8'h4c; i++) begin
      frd(i[21:0], QEXP[i - 16]);
    end
    frd(22'h00004f, 8'h00);
    axi_rd(`FQ_OFF_CMD, d, `FQ_RESP_OKAY);
    `FQ_CHK(d[2:0], 3'd2)
    // An unknown op is acknowledged but must start nothing and leave the last op in place
    axi_wr(`FQ_OFF_CMD, 32'h00000006, `FQ_RESP_OKAY);
    axi_rd(`FQ_OFF_CMD, d, `FQ_RESP_OKAY);
    `FQ_CHK(d[2:0], 3'd2)
    st_chk(2'd2, 1'b0);
    fl_op(fq_pkg::FQ_OP_RESET, 22'h3fffff, 8'h00);
    st_chk(2'd0, 1'b0);
    frd(22'h000011, 8'h11 ^ 8'ha5);
    fl_op(fq_pkg::FQ_OP_WRITE, 22'h000555, 8'h90);
    st_chk(2'd1, 1'b0);
    frd(22'h000001, ID_CODE);
    fl_op(fq_pkg::FQ_OP_QUERY, 22'h000000, 8'h00);
    frd(22'h000010, 8'h51);
    fl_op(fq_pkg::FQ_OP_RESET, 22'h000123, 8'h00);
    st_chk(2'd1, 1'b0);
    `FQ_CHK(mdl_mode, 2'd1)
    fl_op(fq_pkg::FQ_OP_RESET, 22'h000000, 8'h00);
    `FQ_CHK(mdl_mode, 2'd0)
    fl_op(fq_pkg::FQ_OP_QUERY, 22'h000000, 8'h00);
    fl_op(fq_pkg::FQ_OP_WRITE, 22'h2aa55a, 8'h12);
    `FQ_CHK({last_addr, last_data}, {22'h2aa55a, 8'h12})
    `FQ_CHK(mdl_mode, 2'd0)
    st_chk(2'd0, 1'b0);
    fl_op(fq_pkg::FQ_OP_POLL, 22'h000020, 8'h00);
    st_chk(2'd0, 1'b0);
    timeout_status_bit <= 1'b1;
    fl_op(fq_pkg::FQ_OP_POLL, 22'h000020, 8'h00);
    st_chk(2'd0, 1'b1);
    timeout_status_bit <= 1'b0;
    fl_op(fq_pkg::FQ_OP_RESET, 22'h000000, 8'h00);
    st_chk(2'd0, 1'b0);
    // Mid-run reset with the bus idle: the op register must come back cleared
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(`FQ_OFF_CMD, d, `FQ_RESP_OKAY);
    `FQ_CHK(d[2:0], 3'd0)
    st_chk(2'd0, 1'b0);
    give_verdict();
  end
endmodule
